// file: verilog/tps_sequencer.sv
`timescale 1ns/1ps
// How it works
// - Rails held low until enable seen high.
// - Enable runs timers releasing rails one by one.
// - Enable low starts timed pull-low steps.
// - Six independent delays, three up, three down.
// - Enable dropping before first release restarts idle.
// - Late enable drop finishes power-up first.
// - Then 120 ms pause before power-down.
// - Late enable rise finishes power-down first.
// - Then 120 ms pause before power-up.
// - All delays count the one master clock.
// - Timers one and four get 400 us extra.
// - Default order up 1-2-3, down 3-2-1.
// - Rail outputs are open drain, pull low only.
// - Build option picks one of six down orders.
// - Build options set each of the six step delays.
module tps_sequencer #(
  parameter int unsigned CNT_W   = tps_pkg::CNT_W,
  parameter logic [2:0]  DOWN_ORD = tps_pkg::ORDER_321,
  parameter int unsigned D1_CYC  = tps_pkg::STEP_CYC,
  parameter int unsigned D2_CYC  = tps_pkg::STEP_CYC,
  parameter int unsigned D3_CYC  = tps_pkg::STEP_CYC,
  parameter int unsigned D4_CYC  = tps_pkg::STEP_CYC,
  parameter int unsigned D5_CYC  = tps_pkg::STEP_CYC,
  parameter int unsigned D6_CYC  = tps_pkg::STEP_CYC,
  parameter int unsigned REF_CYC = tps_pkg::REFRESH_CYC,
  parameter int unsigned SET_CYC = tps_pkg::SETTLE_CYC
)
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_seq_en,
  input  wire logic [2:0] i_rail_release,
  output logic      [2:0] o_rail_release,
  output logic      [2:0] o_rail_release_oe,
  output logic            o_seq_busy,
  output logic            o_rails_up
);

  typedef struct packed
  {
    logic               en_s1;
    logic               en_s2;
    tps_pkg::tps_state_t st;
    logic [1:0]         step;
    logic               pend;
    logic               settle_up;
    logic [2:0]         rail;
  } tps_st_t;

  tps_st_t s_r;
  tps_st_t s_nxt;

  tps_tmr_if #(.CNT_W(CNT_W)) tif ();

  tps_timer #(.CNT_W(CNT_W)) u_timer
  (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .tmr      (tif)
  );

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [1:0] down_rail(input logic [2:0] ord,
                                           input logic [1:0] stp);
    logic [5:0] seq;
    seq = 6'h00;
    case (ord)
      tps_pkg::ORDER_312: seq = {2'd1, 2'd0, 2'd2};
      tps_pkg::ORDER_231: seq = {2'd0, 2'd2, 2'd1};
      tps_pkg::ORDER_213: seq = {2'd2, 2'd0, 2'd1};
      tps_pkg::ORDER_132: seq = {2'd1, 2'd2, 2'd0};
      tps_pkg::ORDER_123: seq = {2'd2, 2'd1, 2'd0};
      default:            seq = {2'd0, 2'd1, 2'd2};
    endcase
    if (ord == tps_pkg::ORDER_213)
    begin
      seq = {2'd2, 2'd0, 2'd1};
    end
    down_rail = seq[2*stp +: 2];
  endfunction

  function automatic logic [CNT_W-1:0] up_delay(input logic [1:0] stp);
    case (stp)
      2'd0:    up_delay = CNT_W'(D1_CYC + REF_CYC);
      2'd1:    up_delay = CNT_W'(D2_CYC);
      default: up_delay = CNT_W'(D3_CYC);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] dn_delay(input logic [1:0] stp);
    case (stp)
      2'd0:    dn_delay = CNT_W'(D4_CYC + REF_CYC);
      2'd1:    dn_delay = CNT_W'(D5_CYC);
      default: dn_delay = CNT_W'(D6_CYC);
    endcase
  endfunction

  logic en;
  assign en = s_r.en_s2;

  // ==========================================================
  // Sequence control
  // ==========================================================
  always_comb
  begin
    s_nxt       = s_r;
    tif.load    = 1'b0;
    tif.count   = '0;
    s_nxt.en_s1 = i_seq_en;
    s_nxt.en_s2 = s_r.en_s1;
    case (s_r.st)
      tps_pkg::ST_OFF:
      begin
        if (en)
        begin
          s_nxt.st   = tps_pkg::ST_UP;
          s_nxt.step = tps_pkg::STEP_RST;
          s_nxt.pend = 1'b0;
          tif.load   = 1'b1;
          tif.count  = up_delay(2'd0);
        end
      end
      tps_pkg::ST_UP:
      begin
        if (!en && s_r.step == 2'd0)
        begin
          s_nxt.st = tps_pkg::ST_OFF;
          tif.load = 1'b1;
        end
        else if (!en && !s_r.pend)
        begin
          s_nxt.pend = 1'b1;
          tif.load   = 1'b1;
          tif.count  = up_delay(s_r.step);
        end
        else if (tif.done)
        begin
          s_nxt.rail[s_r.step] = 1'b1;
          if (s_r.step == 2'd2)
          begin
            if (s_r.pend)
            begin
              s_nxt.st        = tps_pkg::ST_SETTLE;
              s_nxt.settle_up = 1'b0;
              tif.load        = 1'b1;
              tif.count       = CNT_W'(SET_CYC);
            end
            else
            begin
              s_nxt.st = tps_pkg::ST_ON;
            end
          end
          else
          begin
            s_nxt.step = s_r.step + 2'd1;
            tif.load   = 1'b1;
            tif.count  = up_delay(s_r.step + 2'd1);
          end
        end
      end
      tps_pkg::ST_ON:
      begin
        if (!en)
        begin
          s_nxt.st   = tps_pkg::ST_DOWN;
          s_nxt.step = tps_pkg::STEP_RST;
          s_nxt.pend = 1'b0;
          tif.load   = 1'b1;
          tif.count  = dn_delay(2'd0);
        end
      end
      tps_pkg::ST_DOWN:
      begin
        if (en && s_r.step == 2'd0)
        begin
          s_nxt.st = tps_pkg::ST_ON;
          tif.load = 1'b1;
        end
        else if (en && !s_r.pend)
        begin
          s_nxt.pend = 1'b1;
          tif.load   = 1'b1;
          tif.count  = dn_delay(s_r.step);
        end
        else if (tif.done)
        begin
          s_nxt.rail[down_rail(DOWN_ORD, s_r.step)] = 1'b0;
          if (s_r.step == 2'd2)
          begin
            if (s_r.pend)
            begin
              s_nxt.st        = tps_pkg::ST_SETTLE;
              s_nxt.settle_up = 1'b1;
              tif.load        = 1'b1;
              tif.count       = CNT_W'(SET_CYC);
            end
            else
            begin
              s_nxt.st = tps_pkg::ST_OFF;
            end
          end
          else
          begin
            s_nxt.step = s_r.step + 2'd1;
            tif.load   = 1'b1;
            tif.count  = dn_delay(s_r.step + 2'd1);
          end
        end
      end
      tps_pkg::ST_SETTLE:
      begin
        if (tif.done)
        begin
          s_nxt.step = tps_pkg::STEP_RST;
          s_nxt.pend = 1'b0;
          tif.load   = 1'b1;
          if (s_r.settle_up)
          begin
            s_nxt.st  = tps_pkg::ST_UP;
            tif.count = up_delay(2'd0);
          end
          else
          begin
            s_nxt.st  = tps_pkg::ST_DOWN;
            tif.count = dn_delay(2'd0);
          end
        end
      end
      default:
      begin
        s_nxt.st   = tps_pkg::ST_OFF;
        s_nxt.rail = tps_pkg::RAIL_RST;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_r <= '{en_s1: 1'b0, en_s2: 1'b0, st: tps_pkg::ST_OFF,
               step: tps_pkg::STEP_RST, pend: 1'b0, settle_up: 1'b0,
               rail: tps_pkg::RAIL_RST};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Open-drain rail outputs
  // ==========================================================
  assign o_rail_release    = 3'h0;
  assign o_rail_release_oe = ~s_r.rail;
  assign o_seq_busy        = (s_r.st != tps_pkg::ST_OFF) &&
                             (s_r.st != tps_pkg::ST_ON);
  assign o_rails_up        = (s_r.st == tps_pkg::ST_ON);

endmodule

// file: inc/tps_pkg.sv
package tps_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned STEP_MS        = 10;
  localparam int unsigned SETTLE_MS      = 120;
  localparam int unsigned REFRESH_US     = 400;
  localparam int unsigned STEP_CYC       = STEP_MS * 1000 * CLK_MHZ;
  localparam int unsigned SETTLE_CYC     = SETTLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned REFRESH_CYC    = REFRESH_US * CLK_MHZ;
  localparam int unsigned CNT_W          = 32;

  // ==========================================================
  // Power-down orderings
  // ==========================================================
  localparam logic [2:0] ORDER_321       = 3'h1;
  localparam logic [2:0] ORDER_312       = 3'h2;
  localparam logic [2:0] ORDER_231       = 3'h3;
  localparam logic [2:0] ORDER_213       = 3'h4;
  localparam logic [2:0] ORDER_132       = 3'h5;
  localparam logic [2:0] ORDER_123       = 3'h6;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [2:0] RAIL_RST        = 3'h0;
  localparam logic [1:0] STEP_RST        = 2'h0;

  typedef enum logic [2:0]
  {
    ST_OFF    = 3'b000,
    ST_UP     = 3'b001,
    ST_ON     = 3'b010,
    ST_DOWN   = 3'b011,
    ST_SETTLE = 3'b100
  } tps_state_t;

endpackage

// file: inc/tps_tmr_if.sv
`timescale 1ns/1ps
interface tps_tmr_if #(parameter int unsigned CNT_W = 32);
  logic             load;
  logic [CNT_W-1:0] count;
  logic             done;

  modport ctl
  (
    output load,
    output count,
    input  done
  );

  modport tmr
  (
    input  load,
    input  count,
    output done
  );
endinterface

// file: verilog/tps_timer.sv
`timescale 1ns/1ps
module tps_timer #(parameter int unsigned CNT_W = 32)
(
  input  wire logic  i_clk,
  input  wire logic  i_arst_n,
  tps_tmr_if.tmr     tmr
);

  typedef struct packed
  {
    logic [CNT_W-1:0] cnt;
    logic             busy;
  } tps_tmr_st_t;

  tps_tmr_st_t s_r;
  tps_tmr_st_t s_nxt;

  // ==========================================================
  // Down counter paced by the master clock.
  // ==========================================================
  always_comb
  begin
    s_nxt = s_r;
    if (tmr.load)
    begin
      s_nxt.cnt  = tmr.count;
      s_nxt.busy = 1'b1;
    end
    else if (s_r.busy)
    begin
      if (s_r.cnt <= CNT_W'(1))
      begin
        s_nxt.busy = 1'b0;
      end
      s_nxt.cnt = s_r.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Done looks only at the registered busy flag and count, since load is decoded from done.
  assign tmr.done = s_r.busy && (s_r.cnt <= CNT_W'(1));

endmodule

// file: verif/tps_checker.sv
`timescale 1ns/1ps
module tps_checker #(
  parameter int unsigned D1_CYC  = 20,
  parameter int unsigned D2_CYC  = 20,
  parameter int unsigned D3_CYC  = 20,
  parameter int unsigned REF_CYC = 5
)
(
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  input wire logic       i_seq_en,
  input wire logic [2:0] i_rail_release,
  input wire logic [2:0] o_rail_release,
  input wire logic [2:0] o_rail_release_oe,
  input wire logic       o_seq_busy,
  input wire logic       o_rails_up
);
  logic [2:0]  prev_r;
  logic [31:0] gap_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ==========================================================
  // Cycles since the last rail change
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      prev_r <= 3'h7;
      gap_r  <= 32'h0000_0000;
    end
    else
    begin
      prev_r <= o_rail_release_oe;
      gap_r  <= (o_rail_release_oe != prev_r) ? 32'h0000_0000 : gap_r + 1;
    end
  end
  sequence s_step1; $fell(o_rail_release_oe[0]); endsequence
  sequence s_step2; $fell(o_rail_release_oe[1]); endsequence
  sequence s_step3; $fell(o_rail_release_oe[2]); endsequence
  // ==========================================================
  // Assertions
  // ==========================================================
  drain_zero_a: assert property (o_rail_release == 3'h0)
    else $error("drain data not zero");
  one_step_a: assert property ($countones(o_rail_release_oe ^
    $past(o_rail_release_oe)) <= 1) else $error("two rails moved at once");
  idle_static_a: assert property (!o_seq_busy ##1 !o_seq_busy
    |-> $stable(o_rail_release_oe)) else $error("rails moved while idle");
  rails_low_a: assert property (o_rail_release_oe == 3'h7 &&
    !o_seq_busy && !i_seq_en |=> o_rail_release_oe == 3'h7)
    else $error("rail released without enable");
  up_order_a: assert property (s_step2 |-> !o_rail_release_oe[0])
    else $error("rail 2 before rail 1");
  up_last_a: assert property (s_step3 |-> o_rail_release_oe[1:0] == 0)
    else $error("rail 3 not last");
  rails_up_a: assert property (o_rails_up |-> o_rail_release_oe == 3'h0
    && !o_seq_busy) else $error("up flag wrong");
  first_gap_a: assert property (s_step1 |-> gap_r >= D1_CYC + REF_CYC - 1)
    else $error("rail 1 released early");
  step2_gap_a: assert property (s_step2 |-> gap_r >= D2_CYC - 1
    && gap_r <= D2_CYC + 8) else $error("rail 2 delay wrong");
  step3_gap_a: assert property (s_step3 |-> gap_r >= D3_CYC - 1
    && gap_r <= D3_CYC + 8) else $error("rail 3 delay wrong");
endmodule
bind tps_sequencer tps_checker #(.D1_CYC(D1_CYC), .D2_CYC(D2_CYC),
  .D3_CYC(D3_CYC), .REF_CYC(REF_CYC)) u_chk (.i_clk(i_clk),
  .i_arst_n(i_arst_n), .i_seq_en(i_seq_en),
  .i_rail_release(i_rail_release), .o_rail_release(o_rail_release),
  .o_rail_release_oe(o_rail_release_oe), .o_seq_busy(o_seq_busy),
  .o_rails_up(o_rails_up));

// file: verif/tps_rail_model.sv
`timescale 1ns/1ps
module tps_rail_model
(
  input  wire logic [2:0] i_oe,
  input  wire logic [2:0] i_drv,
  output logic      [2:0] o_rail
);
  // Pull-up wins whenever the sequencer lets a rail float.
  always_comb
  begin
    for (int k = 0; k < 3; k++)
    begin
      o_rail[k] = i_oe[k] ? i_drv[k] : 1'b1;
    end
  end
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int D1 = 20, D2 = 30, D3 = 40, D4 = 25, D5 = 35, D6 = 45;
  localparam int RF = 8, ST = 60;
  localparam logic [2:0] X1 [6] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1};
  localparam logic [2:0] X2 [6] = '{3'h6, 3'h5, 3'h6, 3'h3, 3'h5, 3'h3};
  logic      clk = 0;
  logic      arst_n = 0;
  logic      en = 0;
  wire [2:0] oe_w [6];
  wire [2:0] drv_w [6];
  wire [2:0] rail_w [6];
  wire       busy_w [6];
  wire       up_w [6];
  int        errors = 0;
  int        n_compared = 0;
  int        cyc = 0;
  always #2.5 clk = ~clk;
  for (genvar k = 0; k < 6; k++)
  begin : g_ord
    tps_sequencer #(.DOWN_ORD(3'(k + 1)), .D1_CYC(D1), .D2_CYC(D2),
      .D3_CYC(D3), .D4_CYC(D4), .D5_CYC(D5), .D6_CYC(D6), .REF_CYC(RF),
      .SET_CYC(ST)) dut (.i_clk(clk), .i_arst_n(arst_n), .i_seq_en(en),
      .i_rail_release(rail_w[k]), .o_rail_release(drv_w[k]),
      .o_rail_release_oe(oe_w[k]), .o_seq_busy(busy_w[k]),
      .o_rails_up(up_w[k]));
    tps_rail_model u_rail (.i_oe(oe_w[k]), .i_drv(drv_w[k]),
      .o_rail(rail_w[k]));
  end
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_oe(logic [2:0] want, int lo, int hi);
    int n;
    n = 0;
    while (oe_w[0] !== want && n <= hi)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    n_compared++;
    if (n < lo || n > hi)
    begin
      errors++;
      $display("wrong value delay expected %0d seen %0d", lo, n);
    end
    @(negedge clk);
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_glitch();
    en = 1'b1;
    repeat (D1) @(negedge clk);
    en = 1'b0;
    repeat (D1 + RF + 10) @(negedge clk);
    chk("oe", 3'h7, oe_w[0]);
    chk("busy", 1'b0, busy_w[0]);
  endtask
  task automatic t_up();
    en = 1'b1;
    wait_oe(3'h6, D1 + RF, D1 + RF + 6);
    wait_oe(3'h4, D2, D2 + 4);
    wait_oe(3'h0, D3, D3 + 4);
    chk("up", 1'b1, up_w[0]);
    chk("rail", 3'h7, rail_w[0]);
    repeat (50) @(negedge clk);
    chk("oe", 3'h0, oe_w[0]);
  endtask
  task automatic t_down();
    en = 1'b0;
    wait_oe(3'h4, D4 + RF, D4 + RF + 6);
    for (int k = 0; k < 6; k++) chk("order1", X1[k], oe_w[k]);
    wait_oe(3'h6, D5, D5 + 4);
    for (int k = 0; k < 6; k++) chk("order2", X2[k], oe_w[k]);
    wait_oe(3'h7, D6, D6 + 4);
    for (int k = 0; k < 6; k++) chk("order3", 3'h7, oe_w[k]);
    chk("busy", 1'b0, busy_w[0]);
  endtask
  task automatic t_abort_up();
    en = 1'b1;
    wait_oe(3'h6, D1 + RF, D1 + RF + 6);
    en = 1'b0;
    wait_oe(3'h4, D2, D2 + 8);
    wait_oe(3'h0, D3, D3 + 4);
    wait_oe(3'h4, ST + D4 + RF, ST + D4 + RF + 8);
    wait_oe(3'h6, D5, D5 + 4);
    wait_oe(3'h7, D6, D6 + 4);
  endtask
  task automatic t_abort_down();
    t_up();
    en = 1'b0;
    wait_oe(3'h4, D4 + RF, D4 + RF + 6);
    en = 1'b1;
    wait_oe(3'h6, D5, D5 + 8);
    wait_oe(3'h7, D6, D6 + 4);
    wait_oe(3'h6, ST + D1 + RF, ST + D1 + RF + 8);
    wait_oe(3'h4, D2, D2 + 4);
    wait_oe(3'h0, D3, D3 + 4);
    chk("up", 1'b1, up_w[0]);
  endtask
  // ==========================================================
  // Main sequence and timeout
  // ==========================================================
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      test_done();
    end
  end
  initial
  begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    chk("oe", 3'h7, oe_w[0]);
    chk("rail", 3'h0, rail_w[0]);
    t_glitch();
    t_up();
    t_down();
    t_abort_up();
    t_abort_down();
    test_done();
  end
endmodule
